//--- logic/lpddr_wr_pkg.sv
package lpddr_wr_pkg;

   // ----------------------------------------
   // Geometry
   // ----------------------------------------
   localparam int NUM_BANKS  = 4;
   localparam int BANK_W     = 2;
   localparam int LANES      = 4;
   localparam int DQ_W       = 32;
   localparam int COL_W      = 10;
   localparam int ROW_W      = 14;
   localparam int ADDR_W     = 15;
   localparam int A10_POS    = 10;
   localparam int BYTE_W     = 8;

   // ----------------------------------------
   // Timing, in ns as printed except tWTR in clocks, and clock period in ps
   // ----------------------------------------
   localparam int CLK_PERIOD_PS = 10000;
   localparam int T_WR_NS       = 15;
   localparam int T_WTR_CK      = 2;
   localparam int T_RP_NS       = 15;
   localparam int T_RAS_NS      = 40;
   localparam int T_WR_CYC  = (T_WR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_RP_CYC  = (T_RP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_RAS_CYC = (T_RAS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W     = 8;

   // ----------------------------------------
   // Command encodings {cs_b, ras_b, cas_b, we_b}
   // ----------------------------------------
   typedef enum logic [3:0] {
      CMD_NOP   = 4'h7,
      CMD_ACT   = 4'h3,
      CMD_RD    = 4'h5,
      CMD_WR    = 4'h4,
      CMD_PRE   = 4'h2,
      CMD_DESEL = 4'h8
   } cmd_e;

   typedef enum logic [1:0] {
      BANK_IDLE,
      BANK_ACTIVE,
      BANK_PRECH
   } bank_e;

   // Command bus sample
   typedef struct packed {
      logic [3:0]        cmd;
      logic [BANK_W-1:0] ba;
      logic [ADDR_W-1:0] addr;
   } cmd_bus_s;

   // One captured data element from the link domain
   typedef struct packed {
      logic [DQ_W-1:0]  data;
      logic [LANES-1:0] mask_b;
   } beat_s;

   // Write delivered into the array
   typedef struct packed {
      logic [BANK_W-1:0] bank;
      logic [ROW_W-1:0]  row;
      logic [COL_W-1:0]  col;
      logic [DQ_W-1:0]   data;
      logic [LANES-1:0]  byte_en;
   } array_wr_s;

endpackage

//--- logic/strobe_capture.sv
`timescale 1ns/1ps
// Link-side capture: each rising strobe edge takes one element; a toggle and
// a held word cross to the core clock.
module strobe_capture #(
   parameter int DQ_W  = 32,
   parameter int LANES = 4
)(
   input  wire logic                  i_strobe_clk,
   input  wire logic                  i_rst_b,
   input  wire logic [DQ_W-1:0]       i_dq,
   input  wire logic [LANES-1:0]      i_dm,
   output logic                       o_toggle,
   output logic [DQ_W+LANES-1:0]      o_beat
);

   typedef struct packed {
      logic                  toggle;
      logic [DQ_W+LANES-1:0] beat;
   } cap_s;

   cap_s state;
   cap_s next_state;

   // ----------------------------------------
   // Capture
   // ----------------------------------------
   // Each rising strobe edge registers one element and its mask
   always_comb
   begin
      next_state        = state;
      next_state.toggle = ~state.toggle;
      next_state.beat   = {i_dq, i_dm};
   end

   // Strobe stops outside bursts, so reset only acts while it toggles
   always_ff @(posedge i_strobe_clk)
   begin
      if (!i_rst_b)
         state <= '0;
      else
         state <= next_state;
   end

   assign o_toggle = state.toggle;
   assign o_beat   = state.beat;

endmodule

//--- logic/lpddr_write_precharge.sv
`timescale 1ns/1ps
module lpddr_write_precharge #(
   parameter int BURST_LEN = 4,
   parameter int WR_CYC    = lpddr_wr_pkg::T_WR_CYC,
   parameter int RP_CYC    = lpddr_wr_pkg::T_RP_CYC,
   parameter int RAS_CYC   = lpddr_wr_pkg::T_RAS_CYC
)(
   input  wire logic                                i_clk,
   input  wire logic                                i_rst_b,
   input  wire logic                                i_ce,
   input  wire logic                                i_strobe_clk,
   input  wire logic                                i_strobe_rst_b,
   input  wire lpddr_wr_pkg::cmd_bus_s              i_cmd,
   input  wire logic [lpddr_wr_pkg::DQ_W-1:0]       i_dq,
   input  wire logic [lpddr_wr_pkg::LANES-1:0]      i_dm,
   output lpddr_wr_pkg::array_wr_s                  o_array_wr,
   output logic                                     o_array_wr_valid,
   output logic [lpddr_wr_pkg::NUM_BANKS-1:0]       o_bank_open,
   output logic [lpddr_wr_pkg::NUM_BANKS-1:0]       o_bank_prech
);

   localparam int NB   = lpddr_wr_pkg::NUM_BANKS;
   localparam int CW   = lpddr_wr_pkg::CNT_W;
   localparam int BW   = lpddr_wr_pkg::BANK_W;
   localparam int HALF = BURST_LEN / 2;
   localparam logic [CW-1:0] WR_N   = CW'(WR_CYC);
   localparam logic [CW-1:0] RP_N   = CW'(RP_CYC);
   localparam logic [CW-1:0] RAS_N  = CW'(RAS_CYC);
   localparam logic [CW-1:0] HALF_N = CW'(HALF);
   localparam logic [CW-1:0] BL_N   = CW'(BURST_LEN);
   localparam logic [CW-1:0] ONE    = 8'h01;

   // Per-bank bookkeeping
   typedef struct packed {
      lpddr_wr_pkg::bank_e              mode;
      logic [lpddr_wr_pkg::ROW_W-1:0]   row;
      logic [CW-1:0]                    ras_cnt;
      logic [CW-1:0]                    rp_cnt;
      logic                             ap_pend;
      logic [CW-1:0]                    ap_wait;
   } bank_s;

   typedef struct packed {
      bank_s [NB-1:0]                       bank;
      logic                                 wr_active;
      logic [BW-1:0]                        wr_bank;
      logic [lpddr_wr_pkg::COL_W-1:0]       wr_col;
      logic [CW-1:0]                        wr_left;
      logic                                 wr_ap;
      logic                                 cut;
      logic [2:0]                           tog_sync;
      lpddr_wr_pkg::beat_s                  beat_meta;
      lpddr_wr_pkg::array_wr_s              out;
      logic                                 out_valid;
      logic [NB-1:0]                        open;
      logic [NB-1:0]                        prech;
   } core_s;

   core_s state;
   core_s next_state;

   logic                                               cap_toggle;
   logic [lpddr_wr_pkg::DQ_W+lpddr_wr_pkg::LANES-1:0]  cap_beat;

   // ----------------------------------------
   // Link domain
   // ----------------------------------------
   strobe_capture #(
      .DQ_W  (lpddr_wr_pkg::DQ_W),
      .LANES (lpddr_wr_pkg::LANES)
   ) u_capture (
      .i_strobe_clk (i_strobe_clk),
      .i_rst_b      (i_strobe_rst_b),
      .i_dq         (i_dq),
      .i_dm         (i_dm),
      .o_toggle     (cap_toggle),
      .o_beat       (cap_beat)
   );

   // ----------------------------------------
   // Core command and bank logic
   // ----------------------------------------
   // Beat word is registered every core edge but used only once the synchronised toggle moved,
   // so it has been stable for two core edges
   always_comb
   begin
      logic                 beat_new;
      logic                 is_act;
      logic                 is_rd;
      logic                 is_wr;
      logic                 is_pre;
      logic                 a10;
      logic [BW-1:0]        ba;
      logic [CW-1:0]        ap_delay;
      beat_new   = 1'b0;
      is_act     = 1'b0;
      is_rd      = 1'b0;
      is_wr      = 1'b0;
      is_pre     = 1'b0;
      a10        = i_cmd.addr[lpddr_wr_pkg::A10_POS];
      ba         = i_cmd.ba;
      ap_delay   = '0;
      next_state = state;
      next_state.out_valid = 1'b0;

      // Toggle crossing: two flops, third for edge detect
      next_state.tog_sync = {state.tog_sync[1:0], cap_toggle};
      next_state.beat_meta = cap_beat;
      beat_new = state.tog_sync[2] ^ state.tog_sync[1];

      unique case (i_cmd.cmd)
         lpddr_wr_pkg::CMD_ACT: is_act = 1'b1;
         lpddr_wr_pkg::CMD_RD:  is_rd  = 1'b1;
         lpddr_wr_pkg::CMD_WR:  is_wr  = 1'b1;
         lpddr_wr_pkg::CMD_PRE: is_pre = 1'b1;
         default:               is_act = 1'b0;
      endcase

      // Row-active and precharge timers, plus auto precharge launch
      for (int b = 0; b < NB; b++)
      begin
         if (state.bank[b].ras_cnt != '0)
            next_state.bank[b].ras_cnt = state.bank[b].ras_cnt - ONE;
         if (state.bank[b].mode == lpddr_wr_pkg::BANK_PRECH)
         begin
            if (state.bank[b].rp_cnt <= ONE)
               next_state.bank[b].mode = lpddr_wr_pkg::BANK_IDLE;
            else
               next_state.bank[b].rp_cnt = state.bank[b].rp_cnt - ONE;
         end
         if (state.bank[b].ap_pend)
         begin
            if (state.bank[b].ap_wait != '0)
               next_state.bank[b].ap_wait = state.bank[b].ap_wait - ONE;
            else if (state.bank[b].ras_cnt == '0)
            begin
               next_state.bank[b].ap_pend = 1'b0;
               next_state.bank[b].mode    = lpddr_wr_pkg::BANK_PRECH;
               next_state.bank[b].rp_cnt  = RP_N;
            end
         end
      end

      // Write data path: one element per captured strobe edge
      if (beat_new && state.wr_active)
      begin
         next_state.out.bank    = state.wr_bank;
         next_state.out.row     = state.bank[state.wr_bank].row;
         next_state.out.col     = state.wr_col;
         next_state.out.data    = state.beat_meta.data;
         next_state.out.byte_en = ~state.beat_meta.mask_b;
         next_state.out_valid   = ~state.cut;
         next_state.wr_col      = state.wr_col + 1'b1;
         next_state.wr_left     = state.wr_left - ONE;
         if (state.wr_left == ONE)
         begin
            next_state.wr_active = 1'b0;
            next_state.cut       = 1'b0;
            if (state.wr_ap)
            begin
               next_state.bank[state.wr_bank].ap_pend = 1'b1;
               next_state.bank[state.wr_bank].ap_wait = WR_N;
            end
         end
      end

      // Commands
      if (i_ce)
      begin
         if (is_act)
         begin
            next_state.bank[ba].mode    = lpddr_wr_pkg::BANK_ACTIVE;
            next_state.bank[ba].row     = i_cmd.addr[lpddr_wr_pkg::ROW_W-1:0];
            next_state.bank[ba].ras_cnt = RAS_N;
         end
         if (is_wr && state.bank[ba].mode == lpddr_wr_pkg::BANK_ACTIVE)
         begin
            next_state.wr_active = 1'b1;
            next_state.wr_bank   = ba;
            next_state.wr_col    = i_cmd.addr[lpddr_wr_pkg::COL_W-1:0];
            next_state.wr_left   = BL_N;
            next_state.wr_ap     = a10;
            next_state.cut       = 1'b0;
         end
         if (is_rd && state.wr_active)
            next_state.cut = 1'b1;
         if (is_rd && a10 && state.bank[ba].mode == lpddr_wr_pkg::BANK_ACTIVE)
         begin
            ap_delay = HALF_N;
            next_state.bank[ba].ap_pend = 1'b1;
            next_state.bank[ba].ap_wait = ap_delay;
         end
         if (is_pre)
         begin
            if (state.wr_active && (a10 || ba == state.wr_bank))
               next_state.cut = 1'b1;
            for (int b = 0; b < NB; b++)
            begin
               if ((a10 || BW'(b) == ba)
                   && state.bank[b].mode == lpddr_wr_pkg::BANK_ACTIVE)
               begin
                  next_state.bank[b].mode    = lpddr_wr_pkg::BANK_PRECH;
                  next_state.bank[b].rp_cnt  = RP_N;
                  next_state.bank[b].ap_pend = 1'b0;
               end
            end
         end
      end

      for (int b = 0; b < NB; b++)
      begin
         next_state.open[b]  = next_state.bank[b].mode == lpddr_wr_pkg::BANK_ACTIVE;
         next_state.prech[b] = next_state.bank[b].mode == lpddr_wr_pkg::BANK_PRECH;
      end
   end

   // Whole core freezes while the clock enable is low; the
   // synchroniser and beat word keep running, so a strobe toggle detected while frozen is lost
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         state <= '0;
      else if (i_ce)
         state <= next_state;
      else
      begin
         state.tog_sync  <= next_state.tog_sync;
         state.beat_meta <= next_state.beat_meta;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_array_wr       = state.out;
   assign o_array_wr_valid = state.out_valid;
   assign o_bank_open      = state.open;
   assign o_bank_prech     = state.prech;

endmodule

//--- bench/lpddr_write_precharge_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bank state and array write checker
// ----------------------------------------
module lpddr_write_precharge_assertions #(
   parameter int RP_CYC = 2
)(
   input wire logic                               i_clk,
   input wire logic                               i_rst_b,
   input wire logic                               i_ce,
   input wire lpddr_wr_pkg::cmd_bus_s             i_cmd,
   input wire logic                               o_array_wr_valid,
   input wire logic [lpddr_wr_pkg::NUM_BANKS-1:0] o_bank_open,
   input wire logic [lpddr_wr_pkg::NUM_BANKS-1:0] o_bank_prech
);
   localparam int RP_LEFT = RP_CYC - 1;
   logic       act;
   logic       pre;
   logic       a10;
   logic [1:0] ba;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);

   // Decoded commands; a frozen cycle takes nothing
   assign act = i_ce && (i_cmd.cmd == lpddr_wr_pkg::CMD_ACT);
   assign pre = i_ce && (i_cmd.cmd == lpddr_wr_pkg::CMD_PRE);
   assign a10 = i_cmd.addr[lpddr_wr_pkg::A10_POS];
   assign ba  = i_cmd.ba;

   // Bank state transitions
   a_act_opens_bank: assert property (act && !o_bank_open[ba] && !o_bank_prech[ba]
      |=> o_bank_open[$past(ba)]) else $error("activate did not open bank");
   a_pre_one_bank: assert property (pre && !a10 && o_bank_open[ba]
      |=> o_bank_prech[$past(ba)] && !o_bank_open[$past(ba)]) else $error("bank not closed");
   a_pre_all_banks: assert property (pre && a10 |=> o_bank_open == 4'h0)
      else $error("close-all left a bank open");
   a_pre_idle_noop: assert property (pre && !a10 && !o_bank_open[ba] && !o_bank_prech[ba]
      |=> !o_bank_prech[$past(ba)]) else $error("idle bank started precharge");
   // Precharge period length, the hazard being an early reopen
   a_prech_length: assert property ($rose(o_bank_prech[1])
      |=> o_bank_prech[1] ##RP_LEFT !o_bank_prech[1]) else $error("bad precharge length");
   a_state_exclusive: assert property ((o_bank_open & o_bank_prech) == 4'h0)
      else $error("bank open and precharging");
   a_auto_close_path: assert property ($fell(o_bank_open[2]) |-> o_bank_prech[2])
      else $error("bank closed without precharge");
   a_write_pulse: assert property (o_array_wr_valid |=> !o_array_wr_valid)
      else $error("array write pulse too long");

   // Main scenarios reached
   c_pre_all: cover property (pre && a10);
   c_auto_prech: cover property ($rose(o_bank_prech[2]));
   c_array_write: cover property (o_array_wr_valid);
endmodule

bind lpddr_write_precharge lpddr_write_precharge_assertions #(.RP_CYC(RP_CYC)) u_chk (
   .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_cmd(i_cmd),
   .o_array_wr_valid(o_array_wr_valid), .o_bank_open(o_bank_open),
   .o_bank_prech(o_bank_prech)
);

//--- bench/lpddr_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Controller stand-in: commands and strobed write data
// ----------------------------------------
module lpddr_ctrl_model (
   input  wire logic             i_clk,
   output lpddr_wr_pkg::cmd_bus_s o_cmd,
   output logic                  o_strobe,
   output logic [31:0]           o_dq,
   output logic [3:0]            o_dm
);
   // Idle bus at time zero
   initial
   begin
      o_cmd    = '{lpddr_wr_pkg::CMD_NOP, 2'h0, 15'h0000};
      o_strobe = 1'h0;
      o_dq     = 32'h0000_0000;
      o_dm     = 4'h0;
   end

   // Command changes only at the falling edge, held a full cycle
   task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [14:0] a);
      @(negedge i_clk);
      o_cmd <= '{c, b, a};
   endtask

   task automatic idle();
      @(negedge i_clk);
      o_cmd.cmd <= lpddr_wr_pkg::CMD_NOP;
   endtask

   // One element per strobe rise; strobe stands low between elements and
   // released data shows its inverse, so stale values are never mistaken
   task automatic beat(input logic [31:0] d, input logic [3:0] m);
      o_dq = d;
      o_dm = m;
      #3 o_strobe = 1'h1;
      #6 o_strobe = 1'h0;
      #3 o_dq = ~d;
      o_dm = ~m;
      #24;
   endtask
endmodule

//--- bench/lpddr_write_precharge_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch %0t got %h exp %h", $time, g, e); end end
module lpddr_write_precharge_tb_top;
   localparam int RAS = 8;
   logic                    i_clk        = 1'h0;
   logic                    i_rst_b      = 1'h0;
   logic                    strobe_rst_b = 1'h0;
   logic                    strobe;
   logic [31:0]             dq;
   logic [3:0]              dm;
   logic [3:0]              bank_open;
   logic [3:0]              bank_prech;
   logic                    arr_valid;
   logic [13:0]             rows [4];
   logic                    ce           = 1'h1;
   lpddr_wr_pkg::cmd_bus_s  cmd;
   lpddr_wr_pkg::array_wr_s arr_wr;
   lpddr_wr_pkg::array_wr_s exp_q [$];
   lpddr_wr_pkg::array_wr_s got_q [$];
   int                      error_cnt = 0;
   int                      compares  = 0;
   int                      n;

   always #5 i_clk = ~i_clk;

   // Long row active time so the lock-out is visible
   lpddr_write_precharge #(.RAS_CYC(RAS)) u_dut (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce), .i_strobe_clk(strobe),
      .i_strobe_rst_b(strobe_rst_b), .i_cmd(cmd), .i_dq(dq), .i_dm(dm),
      .o_array_wr(arr_wr), .o_array_wr_valid(arr_valid),
      .o_bank_open(bank_open), .o_bank_prech(bank_prech)
   );
   lpddr_ctrl_model u_ctrl (.i_clk(i_clk), .o_cmd(cmd), .o_strobe(strobe), .o_dq(dq), .o_dm(dm));

   // Collect every array write
   always @(posedge i_clk)
   begin
      if (arr_valid === 1'h1)
         got_q.push_back(arr_wr);
   end

   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic send(input logic [3:0] c, input logic [1:0] b, input logic [14:0] a);
      u_ctrl.issue(c, b, a);
      u_ctrl.idle();
   endtask

   task automatic put(input logic [1:0] b, input logic [9:0] c, input logic [31:0] d,
                      input logic [3:0] m, input logic keep);
      u_ctrl.beat(d, m);
      if (keep)
         exp_q.push_back('{b, rows[b], c, d, ~m});
   endtask

   task automatic open_bank(input logic [1:0] b, input logic [13:0] r);
      rows[b] = r;
      send(lpddr_wr_pkg::CMD_ACT, b, {1'h0, r});
      `CHK(bank_open[b], 1'h1)
   endtask

   // Writes land about three cycles after their strobe
   task automatic check_writes();
      repeat (8) @(negedge i_clk);
      `CHK(got_q.size(), exp_q.size())
      foreach (exp_q[k])
         if (k < got_q.size())
            `CHK(got_q[k], exp_q[k])
      got_q = {};
      exp_q = {};
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_burst();
      open_bank(2'h0, 14'h1234);
      send(lpddr_wr_pkg::CMD_WR, 2'h0, 15'h0004);
      put(2'h0, 10'h004, 32'h1111_2222, 4'h0, 1'h1);
      put(2'h0, 10'h005, 32'h3333_4444, 4'h1, 1'h1);
      put(2'h0, 10'h006, 32'h5555_6666, 4'h6, 1'h1);
      put(2'h0, 10'h007, 32'h7777_8888, 4'h8, 1'h1);
      check_writes();
      send(lpddr_wr_pkg::CMD_RD, 2'h0, 15'h0004);
      `CHK(bank_open[0], 1'h1)
      $display("burst test done");
   endtask

   task automatic t_b2b();
      open_bank(2'h3, 14'h0abc);
      u_ctrl.issue(lpddr_wr_pkg::CMD_WR, 2'h0, 15'h0010);
      send(lpddr_wr_pkg::CMD_WR, 2'h3, 15'h0020);
      for (int k = 0; k < 4; k++)
         put(2'h3, 10'h020 + 10'(k), 32'h5a5a_0000 + 32'(k), 4'h0, 1'h1);
      check_writes();
      $display("back to back test done");
   endtask

   task automatic t_trunc(input logic isrd, input logic [1:0] b);
      open_bank(b, 14'h0777);
      send(lpddr_wr_pkg::CMD_WR, b, 15'h0040);
      put(b, 10'h040, 32'hcafe_0001, 4'h0, 1'h1);
      put(b, 10'h041, 32'hcafe_0002, 4'h0, 1'h1);
      send(isrd ? lpddr_wr_pkg::CMD_RD : lpddr_wr_pkg::CMD_PRE, b, 15'h0000);
      if (!isrd)
         `CHK({bank_open[b], bank_prech[b]}, 2'h1)
      put(b, 10'h042, 32'hdead_0003, 4'h0, 1'h0);
      put(b, 10'h043, 32'hdead_0004, 4'hf, 1'h0);
      check_writes();
      $display("truncation test done");
   endtask

   task automatic t_pre_all();
      send(lpddr_wr_pkg::CMD_PRE, 2'h2, 15'h0400);
      `CHK({bank_open, bank_prech}, 8'h0b)
      repeat (4) @(negedge i_clk);
      send(lpddr_wr_pkg::CMD_PRE, 2'h2, 15'h0000);
      `CHK(bank_prech, 4'h0)
      // Frozen core must ignore an activate
      ce = 1'h0;
      send(lpddr_wr_pkg::CMD_ACT, 2'h0, 15'h0001);
      `CHK(bank_open[0], 1'h0)
      ce = 1'h1;
      $display("precharge test done");
   endtask

   task automatic t_auto_wr();
      open_bank(2'h2, 14'h0555);
      send(lpddr_wr_pkg::CMD_WR, 2'h2, 15'h0400);
      for (int k = 0; k < 4; k++)
         put(2'h2, 10'(k), 32'h0f0f_0000 + 32'(k), 4'h0, 1'h1);
      n = 0;
      while (n < 30 && bank_prech[2] !== 1'h1)
      begin
         @(negedge i_clk);
         n++;
      end
      `CHK({bank_open[2], bank_prech[2]}, 2'h1)
      check_writes();
      $display("auto precharge test done");
   endtask

   // Read with auto precharge at minimum activate-to-read distance
   task automatic t_ras();
      u_ctrl.issue(lpddr_wr_pkg::CMD_ACT, 2'h3, 15'h0000);
      u_ctrl.issue(lpddr_wr_pkg::CMD_RD, 2'h3, 15'h0400);
      u_ctrl.idle();
      n = 1;
      while (n < 40 && bank_prech[3] !== 1'h1)
      begin
         @(negedge i_clk);
         n++;
      end
      `CHK((n >= RAS) && (n <= RAS + 2), 1'h1)
      $display("lock-out test done");
   endtask

   // Main sequence; a strobe edge inside reset clears the link side
   initial
   begin
      u_ctrl.beat(32'h0000_0000, 4'h0);
      @(negedge i_clk);
      i_rst_b      = 1'h1;
      strobe_rst_b = 1'h1;
      t_burst();
      t_b2b();
      t_trunc(1'h1, 2'h1);
      t_trunc(1'h0, 2'h2);
      t_pre_all();
      t_auto_wr();
      t_ras();
      stop_test();
   end

   // Watchdog well beyond the few microseconds the tests need
   initial
   begin
      #20_000;
      error_cnt++;
      $display("mismatch %0t watchdog expired", $time);
      stop_test();
   end
endmodule
